// file: serial_channel_pins.sv
// Notes on behaviour
// - a character does not start on the transmit pin while clear-to-send is inactive.
// - each channel may time its bits from its external baud clock pin.
// - in synchronous mode the transmit pin carries the shift clock.
// - in synchronous mode the receive pin drives data out and samples data in.
// - in asynchronous mode bits leave on transmit pin, arrive on receive pin.
// - channel 1 transmit-done pin pulses when a character has been sent.
// - channel 1 receive-done pin pulses when a character has been received.
// - transmit, receive, clear-to-send, baud clock pins each selectable as port pins.
// - channel 1 done pins each selectable as output-only port pins.
`include "serial_pins_defs.svh"
`default_nettype none

module serial_channel_pins
   import serial_pins_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // per channel configuration, then the controls of the two channel 1 done pins
   input wire logic [1:0] mode_sync_i,
   input wire logic [1:0] use_ext_clk_i,
   input wire logic [1:0] rx_enable_i,
   input wire logic [1:0][3:0] pin_serial_sel_i,
   input wire logic [1:0][3:0] gpio_out_i,
   input wire logic [1:0][3:0] gpio_oe_i,
   output logic [1:0][3:0] gpio_in_o,
   input wire logic [1:0] flag_serial_sel_i,
   input wire logic [1:0] flag_gpio_i,
   // character streams
   input wire logic [1:0][7:0] tx_data_i,
   input wire logic [1:0] tx_valid_i,
   output logic [1:0] tx_ready_o,
   output logic [1:0][7:0] rx_data_o,
   output logic [1:0] rx_valid_o,
   output logic [1:0] rx_frame_err_o,
   // channel 0 pins
   input wire logic serial_in_ch0_i,
   output logic serial_in_ch0_o,
   output logic serial_in_ch0_oe_o,
   input wire logic serial_out_ch0_i,
   output logic serial_out_ch0_o,
   output logic serial_out_ch0_oe_o,
   input wire logic clear_to_send_ch0_n_i,
   output logic clear_to_send_ch0_n_o,
   output logic clear_to_send_ch0_n_oe_o,
   input wire logic ext_baud_clock_ch0_i,
   output logic ext_baud_clock_ch0_o,
   output logic ext_baud_clock_ch0_oe_o,
   // channel 1 pins
   input wire logic serial_in_ch1_i,
   output logic serial_in_ch1_o,
   output logic serial_in_ch1_oe_o,
   input wire logic serial_out_ch1_i,
   output logic serial_out_ch1_o,
   output logic serial_out_ch1_oe_o,
   input wire logic clear_to_send_ch1_n_i,
   output logic clear_to_send_ch1_n_o,
   output logic clear_to_send_ch1_n_oe_o,
   input wire logic ext_baud_clock_ch1_i,
   output logic ext_baud_clock_ch1_o,
   output logic ext_baud_clock_ch1_oe_o,
   output logic tx_done_flag_ch1_o,
   output logic rx_done_flag_ch1_o
);

   // ----
   // bit-rate tick per channel
   // ----
   top_state_t s_r;
   top_state_t s_nxt;
   logic [1:0] tick_w;
   logic [1:0] bclk_w;
   logic [1:0][3:0] pin_in_w;

   assign bclk_w = {ext_baud_clock_ch1_i, ext_baud_clock_ch0_i};
   assign pin_in_w[0] = {ext_baud_clock_ch0_i, clear_to_send_ch0_n_i,
                         serial_out_ch0_i, serial_in_ch0_i};
   assign pin_in_w[1] = {ext_baud_clock_ch1_i, clear_to_send_ch1_n_i,
                         serial_out_ch1_i, serial_in_ch1_i};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_baud
         baud_if b_if ();
         baud_tick_gen u_baud (
            .sys_clk_i(sys_clk_i),
            .nrst_i(nrst_i),
            .ext_baud_clock_i(bclk_w[g]),
            .use_ext_i(s_r.ch[g].ext_sel),
            .tick_if(b_if.gen)
         );
         assign tick_w[g] = b_if.tick;
      end
   endgenerate

   // ----
   // channel engines
   // ----
   // cts is checked only before a character starts,
   // so a frame in progress finishes instead of being cut
   always_comb begin
      logic rxd;
      logic cts_ok;
      logic sync;
      logic accept;
      logic sample;
      rxd = 1'b1;
      cts_ok = 1'b0;
      sync = 1'b0;
      accept = 1'b0;
      sample = 1'b0;
      s_nxt = s_r;
      for (int c = 0; c < 2; c++) begin
         s_nxt.ch[c].in_s1 = pin_in_w[c];
         s_nxt.ch[c].in_s2 = s_r.ch[c].in_s1;
         s_nxt.ch[c].ext_sel = use_ext_clk_i[c];
         s_nxt.ch[c].tx_done = 1'b0;
         s_nxt.ch[c].rx_done = 1'b0;
         s_nxt.ch[c].rx_valid = 1'b0;
         s_nxt.ch[c].rx_ferr = 1'b0;
         rxd = s_r.ch[c].in_s2[`PIN_RX];
         cts_ok = ~s_r.ch[c].in_s2[`PIN_CTS];
         sync = mode_sync_i[c];
         accept = tx_valid_i[c] & s_r.ch[c].tx_ready;

         // transmitter
         case (s_r.ch[c].tx_st)
            TX_IDLE: begin
               if (accept) begin
                  s_nxt.ch[c].tx_st = TX_SHIFT;
                  s_nxt.ch[c].tx_cnt = 4'h0;
                  if (sync) begin
                     s_nxt.ch[c].tx_sh = {2'b11, tx_data_i[c]};
                     s_nxt.ch[c].tx_bits = `SYNC_FRAME_BITS;
                  end else begin
                     s_nxt.ch[c].tx_sh = {1'b1, tx_data_i[c], 1'b0};
                     s_nxt.ch[c].tx_bits = `ASYNC_FRAME_BITS;
                  end
               end
            end
            TX_SHIFT: begin
               if (tick_w[c]) begin
                  s_nxt.ch[c].tx_cnt = s_r.ch[c].tx_cnt + 4'h1;
                  if (s_r.ch[c].tx_cnt == `OVS_LAST) begin
                     s_nxt.ch[c].tx_sh = {1'b1, s_r.ch[c].tx_sh[9:1]};
                     s_nxt.ch[c].tx_bits = s_r.ch[c].tx_bits - 4'h1;
                     if (s_r.ch[c].tx_bits == `FRAME_LAST_BIT) begin
                        s_nxt.ch[c].tx_st = TX_IDLE;
                        s_nxt.ch[c].tx_done = 1'b1;
                     end
                  end
               end
            end
            default: s_nxt.ch[c].tx_st = TX_IDLE;
         endcase

         // receiver
         case (s_r.ch[c].rx_st)
            RX_IDLE: begin
               if (sync) begin
                  if (rx_enable_i[c] && s_r.ch[c].tx_st == TX_IDLE && !accept) begin
                     s_nxt.ch[c].rx_st = RX_SHIFT;
                     s_nxt.ch[c].rx_cnt = 4'h0;
                     s_nxt.ch[c].rx_bits = `SYNC_FRAME_BITS;
                  end
               end else if (!rxd && pin_serial_sel_i[c][`PIN_RX]) begin
                  s_nxt.ch[c].rx_st = RX_SHIFT;
                  s_nxt.ch[c].rx_cnt = 4'h0;
                  s_nxt.ch[c].rx_bits = `ASYNC_FRAME_BITS;
               end
            end
            RX_SHIFT: begin
               if (tick_w[c]) begin
                  s_nxt.ch[c].rx_cnt = s_r.ch[c].rx_cnt + 4'h1;
                  if (sync) begin
                     sample = (s_r.ch[c].rx_cnt == `OVS_SYNC_SAMPLE);
                  end else begin
                     sample = (s_r.ch[c].rx_cnt == `OVS_MID);
                  end
                  if (sample) begin
                     if (!sync && s_r.ch[c].rx_bits == `ASYNC_FRAME_BITS && rxd) begin
                        // glitch on the line, not a start bit
                        s_nxt.ch[c].rx_st = RX_IDLE;
                     end else begin
                        s_nxt.ch[c].rx_sh = {rxd, s_r.ch[c].rx_sh[9:1]};
                        s_nxt.ch[c].rx_bits = s_r.ch[c].rx_bits - 4'h1;
                        if (s_r.ch[c].rx_bits == `FRAME_LAST_BIT) begin
                           s_nxt.ch[c].rx_st = RX_IDLE;
                           s_nxt.ch[c].rx_done = 1'b1;
                           if (sync) begin
                              s_nxt.ch[c].rx_data = {rxd, s_r.ch[c].rx_sh[9:3]};
                              s_nxt.ch[c].rx_valid = 1'b1;
                           end else if (rxd) begin
                              s_nxt.ch[c].rx_data = s_r.ch[c].rx_sh[9:2];
                              s_nxt.ch[c].rx_valid = 1'b1;
                           end else begin
                              s_nxt.ch[c].rx_ferr = 1'b1;
                           end
                        end
                     end
                  end
               end
            end
            default: s_nxt.ch[c].rx_st = RX_IDLE;
         endcase

         // ready only while a new character may start right away
         s_nxt.ch[c].tx_ready = (s_nxt.ch[c].tx_st == TX_IDLE) && cts_ok
                                && pin_serial_sel_i[c][`PIN_TX]
                                && (!sync || (s_nxt.ch[c].rx_st == RX_IDLE
                                              && pin_serial_sel_i[c][`PIN_RX]));

         // pins: port function first, serial function overrides
         s_nxt.ch[c].pout = gpio_out_i[c];
         s_nxt.ch[c].poe = gpio_oe_i[c];
         if (pin_serial_sel_i[c][`PIN_TX]) begin
            s_nxt.ch[c].poe[`PIN_TX] = 1'b1;
            if (sync) begin
               if (s_nxt.ch[c].tx_st == TX_SHIFT) begin
                  s_nxt.ch[c].pout[`PIN_TX] = s_nxt.ch[c].tx_cnt[3];
               end else if (s_nxt.ch[c].rx_st == RX_SHIFT) begin
                  s_nxt.ch[c].pout[`PIN_TX] = s_nxt.ch[c].rx_cnt[3];
               end else begin
                  s_nxt.ch[c].pout[`PIN_TX] = 1'b1;
               end
            end else if (s_nxt.ch[c].tx_st == TX_SHIFT) begin
               s_nxt.ch[c].pout[`PIN_TX] = s_nxt.ch[c].tx_sh[0];
            end else begin
               s_nxt.ch[c].pout[`PIN_TX] = 1'b1;
            end
         end
         if (pin_serial_sel_i[c][`PIN_RX]) begin
            s_nxt.ch[c].pout[`PIN_RX] = s_nxt.ch[c].tx_sh[0];
            s_nxt.ch[c].poe[`PIN_RX] = sync && (s_nxt.ch[c].tx_st == TX_SHIFT);
         end
         if (pin_serial_sel_i[c][`PIN_CTS]) begin
            s_nxt.ch[c].pout[`PIN_CTS] = 1'b0;
            s_nxt.ch[c].poe[`PIN_CTS] = 1'b0;
         end
         if (pin_serial_sel_i[c][`PIN_BCLK]) begin
            s_nxt.ch[c].pout[`PIN_BCLK] = 1'b0;
            s_nxt.ch[c].poe[`PIN_BCLK] = 1'b0;
         end

         // done pins are output only
         if (flag_serial_sel_i[0]) begin
            s_nxt.ch[c].flag[0] = s_nxt.ch[c].tx_done;
         end else begin
            s_nxt.ch[c].flag[0] = flag_gpio_i[0];
         end
         if (flag_serial_sel_i[1]) begin
            s_nxt.ch[c].flag[1] = s_nxt.ch[c].rx_done;
         end else begin
            s_nxt.ch[c].flag[1] = flag_gpio_i[1];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----
   // outputs
   // ----
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         gpio_in_o[c] = s_r.ch[c].in_s2;
         tx_ready_o[c] = s_r.ch[c].tx_ready;
         rx_data_o[c] = s_r.ch[c].rx_data;
         rx_valid_o[c] = s_r.ch[c].rx_valid;
         rx_frame_err_o[c] = s_r.ch[c].rx_ferr;
      end
   end

   assign serial_in_ch0_o = s_r.ch[0].pout[`PIN_RX];
   assign serial_in_ch0_oe_o = s_r.ch[0].poe[`PIN_RX];
   assign serial_out_ch0_o = s_r.ch[0].pout[`PIN_TX];
   assign serial_out_ch0_oe_o = s_r.ch[0].poe[`PIN_TX];
   assign clear_to_send_ch0_n_o = s_r.ch[0].pout[`PIN_CTS];
   assign clear_to_send_ch0_n_oe_o = s_r.ch[0].poe[`PIN_CTS];
   assign ext_baud_clock_ch0_o = s_r.ch[0].pout[`PIN_BCLK];
   assign ext_baud_clock_ch0_oe_o = s_r.ch[0].poe[`PIN_BCLK];
   assign serial_in_ch1_o = s_r.ch[1].pout[`PIN_RX];
   assign serial_in_ch1_oe_o = s_r.ch[1].poe[`PIN_RX];
   assign serial_out_ch1_o = s_r.ch[1].pout[`PIN_TX];
   assign serial_out_ch1_oe_o = s_r.ch[1].poe[`PIN_TX];
   assign clear_to_send_ch1_n_o = s_r.ch[1].pout[`PIN_CTS];
   assign clear_to_send_ch1_n_oe_o = s_r.ch[1].poe[`PIN_CTS];
   assign ext_baud_clock_ch1_o = s_r.ch[1].pout[`PIN_BCLK];
   assign ext_baud_clock_ch1_oe_o = s_r.ch[1].poe[`PIN_BCLK];
   // only channel 1 brings its done pulses to pins
   assign tx_done_flag_ch1_o = s_r.ch[1].flag[0];
   assign rx_done_flag_ch1_o = s_r.ch[1].flag[1];

endmodule

`default_nettype wire

// file: serial_pins_defs.svh
`ifndef SERIAL_PINS_DEFS_SVH
`define SERIAL_PINS_DEFS_SVH

// ----
// pin slots inside a channel
// ----
`define PIN_RX 2'd0
`define PIN_TX 2'd1
`define PIN_CTS 2'd2
`define PIN_BCLK 2'd3

// ----
// oversampling and frame sizes
// ----
`define OVS_LAST 4'hf
`define OVS_MID 4'h7
`define OVS_SYNC_SAMPLE 4'hc
`define ASYNC_FRAME_BITS 4'ha
`define SYNC_FRAME_BITS 4'h8
`define FRAME_LAST_BIT 4'h1

// ----
// bit-rate sources
// ----
// internal divider: one oversampling tick every this many sys clocks
`define INT_BAUD_DIV 8'h44
// the external baud clock may run at most at sys clock divided by this
`define EXT_BAUD_MAX_RATIO 2

`endif

// file: serial_pins_pkg.sv
`default_nettype none

package serial_pins_pkg;

   typedef enum logic [0:0] {
      TX_IDLE = 1'b0,
      TX_SHIFT = 1'b1
   } tx_state_t;

   typedef enum logic [0:0] {
      RX_IDLE = 1'b0,
      RX_SHIFT = 1'b1
   } rx_state_t;

   typedef struct packed {
      logic [3:0] in_s1;
      logic [3:0] in_s2;
      logic ext_sel;
      tx_state_t tx_st;
      logic [9:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_cnt;
      logic tx_ready;
      logic tx_done;
      rx_state_t rx_st;
      logic [9:0] rx_sh;
      logic [3:0] rx_bits;
      logic [3:0] rx_cnt;
      logic [7:0] rx_data;
      logic rx_valid;
      logic rx_ferr;
      logic rx_done;
      logic [3:0] pout;
      logic [3:0] poe;
      logic [1:0] flag;
   } chan_t;

   typedef struct packed {
      chan_t [1:0] ch;
   } top_state_t;

   typedef struct packed {
      logic tog_s1;
      logic tog_s2;
      logic tog_s3;
      logic [7:0] div_cnt;
      logic tick;
   } baud_state_t;

endpackage

`default_nettype wire

// file: baud_if.sv
`default_nettype none

interface baud_if;
   logic tick;
   modport gen (output tick);
   modport use_side (input tick);
endinterface

`default_nettype wire

// file: baud_tick_gen.sv
`include "serial_pins_defs.svh"
`default_nettype none

module baud_tick_gen
   import serial_pins_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ext_baud_clock_i,
   input wire logic use_ext_i,
   baud_if.gen tick_if
);

   // ----
   // link domain: one toggle per external baud clock rising edge
   // ----
   // the peer keeps this clock at or below half the sys clock, so every
   // toggle is held for at least two sys edges and cannot be missed
   logic ext_tog_r;

   always_ff @(posedge ext_baud_clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_tog_r <= 1'b0;
      end else begin
         ext_tog_r <= ~ext_tog_r;
      end
   end

   // ----
   // sys domain: toggle synchroniser and internal divider
   // ----
   baud_state_t s_r;
   baud_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.tog_s1 = ext_tog_r;
      s_nxt.tog_s2 = s_r.tog_s1;
      s_nxt.tog_s3 = s_r.tog_s2;
      if (s_r.div_cnt == `INT_BAUD_DIV - 8'h01) begin
         s_nxt.div_cnt = 8'h00;
      end else begin
         s_nxt.div_cnt = s_r.div_cnt + 8'h01;
      end
      if (use_ext_i) begin
         s_nxt.tick = s_r.tog_s2 ^ s_r.tog_s3;
      end else begin
         s_nxt.tick = (s_r.div_cnt == `INT_BAUD_DIV - 8'h01);
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick_if.tick = s_r.tick;

endmodule

`default_nettype wire

// file: serial_channel_pins_props.sv
`default_nettype none
module serial_channel_pins_props (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [1:0] mode_sync_i,
   input wire logic [1:0][3:0] pin_serial_sel_i,
   input wire logic [1:0][3:0] gpio_out_i,
   input wire logic [1:0][3:0] gpio_oe_i,
   input wire logic [1:0] flag_serial_sel_i,
   input wire logic [1:0] flag_gpio_i,
   input wire logic [1:0] tx_valid_i,
   input wire logic [1:0] tx_ready_o,
   input wire logic [1:0] rx_valid_o,
   input wire logic [1:0] rx_frame_err_o,
   input wire logic serial_in_ch0_o,
   input wire logic serial_in_ch0_oe_o,
   input wire logic serial_out_ch0_o,
   input wire logic serial_out_ch0_oe_o,
   input wire logic serial_out_ch1_o,
   input wire logic clear_to_send_ch1_n_i,
   input wire logic tx_done_flag_ch1_o,
   input wire logic rx_done_flag_ch1_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // pin level properties
   // ----
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // cts passes a 2-ff sync, so four cycles off must have reached ready
   property p_cts_hold;
      (clear_to_send_ch1_n_i && pin_serial_sel_i[1][2])[*4] |-> !tx_ready_o[1];
   endproperty
   a_cts_hold: assert property (p_cts_hold) else $error("ready while cts off");
   property p_tx_start;
      tx_valid_i[1] && tx_ready_o[1] && !mode_sync_i[1] && pin_serial_sel_i[1][1]
         |=> !serial_out_ch1_o && !tx_ready_o[1];
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("no start bit");
   property p_sync_clk;
      (mode_sync_i[0] && pin_serial_sel_i[0][1])[*2]
         |-> serial_out_ch0_oe_o && (serial_out_ch0_o || !tx_ready_o[0]);
   endproperty
   a_sync_clk: assert property (p_sync_clk) else $error("sync clock pin wrong");
   property p_sync_data;
      mode_sync_i[0] && pin_serial_sel_i[0][0] && tx_valid_i[0] && tx_ready_o[0]
         |-> ##[1:3] serial_in_ch0_oe_o;
   endproperty
   a_sync_data: assert property (p_sync_data) else $error("data pin not driven");
   property p_tx_flag;
      tx_done_flag_ch1_o && flag_serial_sel_i[0] && !mode_sync_i[1]
         |-> serial_out_ch1_o ##1 !tx_done_flag_ch1_o;
   endproperty
   a_tx_flag: assert property (p_tx_flag) else $error("tx done flag wrong");
   property p_rx_flag;
      $past(flag_serial_sel_i[1]) && flag_serial_sel_i[1]
         |-> rx_done_flag_ch1_o == (rx_valid_o[1] || rx_frame_err_o[1]);
   endproperty
   a_rx_flag: assert property (p_rx_flag) else $error("rx done flag wrong");
   property p_flag_port;
      (flag_serial_sel_i == 2'h0)[*2]
         |-> {rx_done_flag_ch1_o, tx_done_flag_ch1_o} == $past(flag_gpio_i);
   endproperty
   a_flag_port: assert property (p_flag_port) else $error("flag port value wrong");
   property p_gpio_rx;
      (!pin_serial_sel_i[0][0])[*2] |-> serial_in_ch0_oe_o == $past(gpio_oe_i[0][0])
         && (!serial_in_ch0_oe_o || serial_in_ch0_o == $past(gpio_out_i[0][0]));
   endproperty
   a_gpio_rx: assert property (p_gpio_rx) else $error("port pin wrong");
endmodule
`default_nettype wire

// file: serial_peer_model.sv
`default_nettype none
module serial_peer_model (
   input wire logic tx_line_i,
   input wire logic rx_line_i,
   output logic rx_drive_o,
   output logic rx_drive_en_o,
   output logic cts_n_o,
   output logic baud_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic baud_run;
   // ----
   // link clock and line drivers
   // ----
   // baud clock idles low; 160 ns is well under sys/2
   initial begin
      rx_drive_o = 1'b1;
      rx_drive_en_o = 1'b0;
      cts_n_o = 1'b0;
      baud_clk_o = 1'b0;
      baud_run = 1'b0;
      #3.3;
      forever begin
         #80;
         baud_clk_o = baud_run ? ~baud_clk_o : 1'b0;
      end
   end
   task set_cts(input logic v);
      cts_n_o = v;
   endtask
   task set_baud(input logic on);
      baud_run = on;
   endtask
   task send_async(input logic [7:0] d, input int bit_ns);
      logic [9:0] fr;
      fr = {1'b1, d, 1'b0};
      rx_drive_en_o = 1'b1;
      for (int i = 0; i < 10; i++) begin
         rx_drive_o = fr[i];
         #(bit_ns);
      end
      // released line rises through the pull-up, the last bit is not held
      rx_drive_en_o = 1'b0;
      rx_drive_o = 1'b0;
   endtask
   task get_async(output logic [7:0] d, input int bit_ns);
      @(negedge tx_line_i);
      #(bit_ns / 2);
      for (int i = 0; i < 8; i++) begin
         #(bit_ns);
         d[i] = tx_line_i;
      end
   endtask
   // bits change on clock falls; no fall follows the last rise
   task put_sync(input logic [7:0] d);
      rx_drive_en_o = 1'b1;
      for (int i = 0; i < 8; i++) begin
         rx_drive_o = d[i];
         @(posedge tx_line_i);
         if (i < 7) @(negedge tx_line_i);
      end
      #3000;
      rx_drive_en_o = 1'b0;
   endtask
   task get_sync(output logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         @(posedge tx_line_i);
         d[i] = rx_line_i;
      end
   endtask
endmodule
`default_nettype wire

// file: serial_channel_pins_tb_top.sv
`default_nettype none
module serial_channel_pins_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic nrst_i;
   logic [1:0] mode_sync_i, use_ext_clk_i, rx_enable_i, flag_serial_sel_i, flag_gpio_i;
   logic [1:0] tx_valid_i, tx_ready_o, rx_valid_o, rx_frame_err_o, prx, prx_en, pcts, pbclk;
   logic [1:0][3:0] pin_serial_sel_i, gpio_out_i, gpio_oe_i, gpio_in_o, po, poe, pen, pval, lvl;
   logic [1:0][7:0] tx_data_i, rx_data_o;
   logic serial_in_ch0_o, serial_in_ch0_oe_o, serial_out_ch0_o, serial_out_ch0_oe_o;
   logic clear_to_send_ch0_n_o, clear_to_send_ch0_n_oe_o, ext_baud_clock_ch0_o;
   logic ext_baud_clock_ch0_oe_o, serial_in_ch1_o, serial_in_ch1_oe_o, serial_out_ch1_o;
   logic serial_out_ch1_oe_o, clear_to_send_ch1_n_o, clear_to_send_ch1_n_oe_o;
   logic ext_baud_clock_ch1_o, ext_baud_clock_ch1_oe_o, tx_done_flag_ch1_o, rx_done_flag_ch1_o;
   int failures;
   int total_checks;
   always #4 sys_clk_i = ~sys_clk_i;
   // ----
   // pin resolution: device, then peer, else the pull-up
   // ----
   assign po = {ext_baud_clock_ch1_o, clear_to_send_ch1_n_o, serial_out_ch1_o, serial_in_ch1_o,
      ext_baud_clock_ch0_o, clear_to_send_ch0_n_o, serial_out_ch0_o, serial_in_ch0_o};
   assign poe = {ext_baud_clock_ch1_oe_o, clear_to_send_ch1_n_oe_o, serial_out_ch1_oe_o,
      serial_in_ch1_oe_o, ext_baud_clock_ch0_oe_o, clear_to_send_ch0_n_oe_o,
      serial_out_ch0_oe_o, serial_in_ch0_oe_o};
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         pen[c] = {2'h3, 1'b0, prx_en[c]};
         pval[c] = {pbclk[c], pcts[c], 1'b1, prx[c]};
         for (int k = 0; k < 4; k++) begin
            lvl[c][k] = poe[c][k] ? po[c][k] : (pen[c][k] ? pval[c][k] : 1'b1);
         end
      end
   end
   serial_channel_pins u_dut (
      .sys_clk_i, .nrst_i, .mode_sync_i, .use_ext_clk_i, .rx_enable_i, .pin_serial_sel_i,
      .gpio_out_i, .gpio_oe_i, .gpio_in_o, .flag_serial_sel_i, .flag_gpio_i, .tx_data_i,
      .tx_valid_i, .tx_ready_o, .rx_data_o, .rx_valid_o, .rx_frame_err_o,
      .serial_in_ch0_i(lvl[0][0]), .serial_in_ch0_o, .serial_in_ch0_oe_o,
      .serial_out_ch0_i(lvl[0][1]), .serial_out_ch0_o, .serial_out_ch0_oe_o,
      .clear_to_send_ch0_n_i(lvl[0][2]), .clear_to_send_ch0_n_o, .clear_to_send_ch0_n_oe_o,
      .ext_baud_clock_ch0_i(lvl[0][3]), .ext_baud_clock_ch0_o, .ext_baud_clock_ch0_oe_o,
      .serial_in_ch1_i(lvl[1][0]), .serial_in_ch1_o, .serial_in_ch1_oe_o,
      .serial_out_ch1_i(lvl[1][1]), .serial_out_ch1_o, .serial_out_ch1_oe_o,
      .clear_to_send_ch1_n_i(lvl[1][2]), .clear_to_send_ch1_n_o, .clear_to_send_ch1_n_oe_o,
      .ext_baud_clock_ch1_i(lvl[1][3]), .ext_baud_clock_ch1_o, .ext_baud_clock_ch1_oe_o,
      .tx_done_flag_ch1_o, .rx_done_flag_ch1_o
   );
   serial_peer_model u_peer0 (.tx_line_i(lvl[0][1]), .rx_line_i(lvl[0][0]),
      .rx_drive_o(prx[0]), .rx_drive_en_o(prx_en[0]), .cts_n_o(pcts[0]), .baud_clk_o(pbclk[0]));
   serial_peer_model u_peer1 (.tx_line_i(lvl[1][1]), .rx_line_i(lvl[1][0]),
      .rx_drive_o(prx[1]), .rx_drive_en_o(prx_en[1]), .cts_n_o(pcts[1]), .baud_clk_o(pbclk[1]));
   // ----
   // tasks
   // ----
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task complete_run;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task send_char(input int c, input logic [7:0] d);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk_i);
         n++;
      end while (tx_ready_o[c] !== 1'b1 && n < 20000);
      if (n >= 20000) failures++;
      @(posedge sys_clk_i);
      tx_data_i[c] <= d;
      tx_valid_i[c] <= 1'b1;
      @(posedge sys_clk_i);
      tx_valid_i[c] <= 1'b0;
   endtask
   task t_port;
      pin_serial_sel_i[0] <= 4'h0;
      gpio_out_i[0] <= 4'h2;
      gpio_oe_i[0] <= 4'h3;
      flag_serial_sel_i <= 2'h0;
      flag_gpio_i <= 2'h2;
      repeat (5) @(negedge sys_clk_i);
      check("port oe", poe[0], 4'h3);
      check("port out", po[0][1:0], 2'h2);
      check("port in", gpio_in_o[0], 4'h2);
      check("flag pins", {rx_done_flag_ch1_o, tx_done_flag_ch1_o}, 2'h2);
      @(posedge sys_clk_i);
      flag_gpio_i <= 2'h1;
      repeat (3) @(negedge sys_clk_i);
      check("flag pins swap", {rx_done_flag_ch1_o, tx_done_flag_ch1_o}, 2'h1);
      @(posedge sys_clk_i);
      pin_serial_sel_i[0] <= 4'hf;
      gpio_oe_i[0] <= 4'h0;
      flag_serial_sel_i <= 2'h3;
      repeat (4) @(posedge sys_clk_i);
      $display("test port_pins done");
   endtask
   task t_cts;
      int busy;
      int low;
      busy = 0;
      low = 0;
      @(negedge sys_clk_i);
      u_peer1.set_cts(1'b1);
      repeat (4) @(posedge sys_clk_i);
      tx_data_i[1] <= 8'h5a;
      tx_valid_i[1] <= 1'b1;
      repeat (200) begin
         @(negedge sys_clk_i);
         busy += (tx_ready_o[1] !== 1'b0);
         low += (lvl[1][1] !== 1'b1);
      end
      @(posedge sys_clk_i);
      tx_valid_i[1] <= 1'b0;
      check("ready while cts off", busy, 0);
      check("tx line while cts off", low, 0);
      @(negedge sys_clk_i);
      u_peer1.set_cts(1'b0);
      repeat (6) @(negedge sys_clk_i);
      check("ready after cts on", tx_ready_o[1], 1'b1);
      $display("test cts_gate done");
   endtask
   task t_atx;
      logic [7:0] d;
      int done;
      done = 0;
      fork
         u_peer1.get_async(d, 8704);
         send_char(1, 8'ha5);
         repeat (11500) begin
            @(negedge sys_clk_i);
            done += (tx_done_flag_ch1_o === 1'b1);
         end
      join
      check("async tx char", d, 8'ha5);
      check("tx done pulses", done, 1);
      $display("test async_tx done");
   endtask
   task t_arx;
      int got;
      int flg;
      got = 0;
      flg = 0;
      use_ext_clk_i[1] <= 1'b1;
      u_peer1.set_baud(1'b1);
      repeat (125) @(posedge sys_clk_i);
      fork
         u_peer1.send_async(8'h3c, 2560);
         repeat (3600) begin
            @(negedge sys_clk_i);
            got += (rx_valid_o[1] === 1'b1);
            flg += (rx_valid_o[1] === 1'b1 && rx_done_flag_ch1_o === 1'b1);
         end
      join
      check("ext clock rx char", rx_data_o[1], 8'h3c);
      check("rx valid pulses", got, 1);
      check("rx done with valid", flg, 1);
      u_peer1.set_baud(1'b0);
      @(posedge sys_clk_i);
      use_ext_clk_i[1] <= 1'b0;
      $display("test async_rx_ext done");
   endtask
   task t_stx;
      logic [7:0] d;
      mode_sync_i[0] <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      fork
         u_peer0.get_sync(d);
         send_char(0, 8'h96);
      join
      repeat (700) @(negedge sys_clk_i);
      check("sync tx char", d, 8'h96);
      check("clock pin driven", serial_out_ch0_oe_o, 1'b1);
      check("clock idles high", serial_out_ch0_o, 1'b1);
      check("data pin released", serial_in_ch0_oe_o, 1'b0);
      fork
         u_peer0.put_sync(8'hc3);
         begin
            @(posedge sys_clk_i);
            rx_enable_i[0] <= 1'b1;
            @(posedge sys_clk_i);
            rx_enable_i[0] <= 1'b0;
         end
      join
      check("sync rx char", rx_data_o[0], 8'hc3);
      @(posedge sys_clk_i);
      mode_sync_i[0] <= 1'b0;
      $display("test sync_tx done");
   endtask
   initial begin
      #400000;
      failures++;
      $display("MISMATCH run time expected end seen timeout");
      complete_run;
   end
   initial begin
      nrst_i = 1'b0;
      mode_sync_i = 2'h0;
      use_ext_clk_i = 2'h0;
      rx_enable_i = 2'h0;
      pin_serial_sel_i = 8'hff;
      gpio_out_i = 8'h00;
      gpio_oe_i = 8'h00;
      flag_serial_sel_i = 2'h3;
      flag_gpio_i = 2'h0;
      tx_data_i = 16'h0000;
      tx_valid_i = 2'h0;
      failures = 0;
      total_checks = 0;
      repeat (4) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      t_port;
      t_cts;
      t_atx;
      t_arx;
      t_stx;
      complete_run;
   end
endmodule
bind serial_channel_pins serial_channel_pins_props u_props (
   .sys_clk_i, .nrst_i, .mode_sync_i, .pin_serial_sel_i, .gpio_out_i, .gpio_oe_i,
   .flag_serial_sel_i, .flag_gpio_i, .tx_valid_i, .tx_ready_o, .rx_valid_o, .serial_in_ch0_o,
   .serial_in_ch0_oe_o, .serial_out_ch0_o, .serial_out_ch0_oe_o, .serial_out_ch1_o,
   .clear_to_send_ch1_n_i, .tx_done_flag_ch1_o, .rx_done_flag_ch1_o, .rx_frame_err_o
);
`default_nettype wire
